// file: logic/two_wire_params.svh
`ifndef TWO_WIRE_PARAMS_SVH
`define TWO_WIRE_PARAMS_SVH
`define REG_COUNT       15
`define OFS_SHARED      4'h0
`define OFS_DUAL        4'h1
`define OFS_DEBUG       4'h2
`define OFS_HCTRL1      4'h3
`define OFS_HCTRL2      4'h4
`define OFS_HSTATUS     4'h5
`define OFS_HBAUD       4'h6
`define OFS_HADDR       4'h7
`define OFS_HDATA       4'h8
`define OFS_CCTRL1      4'h9
`define OFS_CCTRL2      4'hA
`define OFS_CSTATUS     4'hB
`define OFS_CADDR       4'hC
`define OFS_CDATA       4'hD
`define OFS_CMASK       4'hE
`define MASK_SHARED     8'h5E
`define MASK_DUAL       8'h4F
`define MASK_DEBUG      8'h01
`define MASK_HCTRL1     8'hDF
`define MASK_HCTRL2     8'h0C
`define MASK_CCTRL1     8'hE7
`define MASK_CCTRL2     8'h04
`define MASK_FULL       8'hFF
`define REG_RESET       8'h00
`define POS_PAD_LVL     6
`define POS_SETUP       4
`define POS_HOLD_HI     3
`define POS_HOLD_LO     2
`define POS_FMP         1
`define POS_DUAL_EN     0
`define POS_DBG_RUN     0
`define POS_HOST_EN     0
`define POS_FLAG_HI     7
`define POS_FLAG_LO     6
`define HOLD_OFF        2'h0
`define HOLD_SHORT      2'h1
`define HOLD_MID        2'h2
`define CLK_PERIOD_NS   4
`define HOLD_SHORT_NS   50
`define HOLD_MID_NS     300
`define HOLD_LONG_NS    500
`define CEIL_CYC(ns)    (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_FOUR      4
`define SETUP_EIGHT     8
`define ADDR_LAST_BIT   4'h7
`define FRAME_LAST_BIT  4'h8
`endif

// file: logic/two_wire_pkg.sv
package two_wire_pkg;
    typedef enum logic [1:0] {link_idle, link_addr, link_data} link_phase_t;
    typedef struct packed {
        logic [14:0][7:0] regs;
        logic [7:0]       rdata;
        logic             host_irq;
        logic             client_irq;
        logic             host_go;
        logic             host_active;
        logic             pad_host;
        logic             pad_client;
        logic             fmp_host;
        logic             fmp_client;
        logic [7:0]       host_hold;
        logic [7:0]       client_hold;
        logic [3:0]       setup_cycles;
        logic [3:0]       wake_count;
        logic             clock_free;
        logic [2:0]       byte_sync;
        logic [2:0]       addr_sync;
    } sys_state_t;
    typedef struct packed {
        logic [1:0]  run_pipe;
        logic [1:0]  scl_pipe;
        logic [1:0]  sda_pipe;
        logic [1:0]  sleep_pipe;
        logic [1:0]  free_pipe;
        logic [1:0]  dual_pipe;
        logic [6:0]  addr_meta;
        logic [6:0]  addr_sync;
        logic        scl_prev;
        logic        sda_prev;
        link_phase_t phase;
        logic [3:0]  bit_count;
        logic [6:0]  shift;
        logic        byte_toggle;
        logic        addr_toggle;
        logic        stretch;
        logic        wake_request;
        logic        scl_out;
    } link_state_t;
endpackage : two_wire_pkg

// file: logic/two_wire_link.sv
`timescale 1ns/100ps
`default_nettype none
`include "two_wire_params.svh"
module two_wire_link
    import two_wire_pkg::*;
(
    input  wire logic       link_clock,
    input  wire logic       link_nrst,
    input  wire logic       clock_en,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic       sleep,
    input  wire logic       clock_free,
    input  wire logic       dual_en,
    input  wire logic [6:0] client_addr,
    output logic            scl_out,
    output logic            scl_oe,
    output logic            wake_request,
    output logic            byte_toggle,
    output logic            addr_toggle
);
    link_state_t s;
    link_state_t next_s;
    logic        scl;
    logic        sda;
    logic        start;
    logic        stop;
    logic        rise;
    logic        asleep;

    // runs on the bus clock, so it keeps working while the system clock sleeps
    always_comb begin
        scl = s.scl_pipe[1];
        sda = s.sda_pipe[1];
        asleep = s.sleep_pipe[1];
        start = scl && s.scl_prev && s.sda_prev && !sda;
        stop = scl && s.scl_prev && !s.sda_prev && sda;
        rise = scl && !s.scl_prev;
        next_s = s;
        next_s.run_pipe = {s.run_pipe[0], clock_en};
        if (s.run_pipe[1]) begin
            next_s.scl_pipe = {s.scl_pipe[0], scl_in};
            next_s.sda_pipe = {s.sda_pipe[0], sda_in};
            next_s.sleep_pipe = {s.sleep_pipe[0], sleep};
            next_s.free_pipe = {s.free_pipe[0], clock_free};
            next_s.dual_pipe = {s.dual_pipe[0], dual_en};
            next_s.addr_meta = client_addr;
            next_s.addr_sync = s.addr_meta;
            next_s.scl_prev = scl;
            next_s.sda_prev = sda;
            if (start) begin
                next_s.phase = link_addr;
                next_s.bit_count = '0;
                if (asleep && s.dual_pipe[1]) begin
                    next_s.wake_request = 1'b1;
                end
            end else if (stop) begin
                next_s.phase = link_idle;
                next_s.addr_toggle = !s.addr_toggle;
            end else if (rise && s.phase != link_idle) begin
                next_s.shift = {s.shift[5:0], sda};
                next_s.bit_count = s.bit_count + 4'h1;
                if (s.bit_count == `FRAME_LAST_BIT) begin
                    next_s.bit_count = '0;
                    if (s.phase == link_data) begin
                        next_s.byte_toggle = !s.byte_toggle;
                    end
                end
                if (s.phase == link_addr && s.bit_count == `ADDR_LAST_BIT) begin
                    if (s.shift == s.addr_sync) begin
                        next_s.phase = link_data;
                        // the address acknowledge slot is not a data byte
                        next_s.bit_count = '1;
                        next_s.addr_toggle = !s.addr_toggle;
                        // hold the clock low until the system clock is back
                        next_s.stretch = asleep;
                        if (asleep && !s.dual_pipe[1]) begin
                            next_s.wake_request = 1'b1;
                        end
                    end else begin
                        next_s.phase = link_idle;
                    end
                end
            end
            if (s.free_pipe[1]) begin
                next_s.stretch = 1'b0;
            end
            if (!asleep) begin
                next_s.wake_request = 1'b0;
            end
        end
    end

    always_ff @(posedge link_clock) begin
        if (!link_nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign scl_out = s.scl_out;
    assign scl_oe = s.stretch;
    assign wake_request = s.wake_request;
    assign byte_toggle = s.byte_toggle;
    assign addr_toggle = s.addr_toggle;
endmodule : two_wire_link
`default_nettype wire

// file: logic/two_wire_unit.sv
// Overview of operation
// - client byte or address/stop flag raises client request
// - host read or write flag raises host request
// - each event sets its flag; flags ORed
// - bus watch and address match run asleep
// - matched while asleep: stretch clock until awake
// - host ceases operation in any sleep
// - dual mode: wake only on client start
// - debug halt freezes unless keep-running set
// - halted keep-running: data access clears no flag and starts no transfer
// - setup bit: four or eight cycles
// - hold field: none, 50, 300, 500 ns
// - fast-plus bit selects 1 MHz operation
// - dual threshold bit only for client bus
// - dual enable bit runs separate buses
// - frozen controller ignores incoming events
`timescale 1ns/100ps
`default_nettype none
`include "two_wire_params.svh"
module two_wire_unit
    import two_wire_pkg::*;
#(
    parameter int ADDR_W = 4
)(
    input  wire logic              clock,
    input  wire logic              nrst,
    input  wire logic              clock_en,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic       [7:0]       rdata,
    input  wire logic              sleep,
    input  wire logic              cpu_halt,
    input  wire logic              host_read_done,
    input  wire logic              host_write_done,
    output logic                   host_irq,
    output logic                   client_irq,
    output logic                   host_go,
    output logic                   host_active,
    output logic                   pad_host,
    output logic                   pad_client,
    output logic                   fmp_host,
    output logic                   fmp_client,
    output logic       [7:0]       host_hold_cycles,
    output logic       [7:0]       client_hold_cycles,
    output logic       [3:0]       setup_cycles,
    input  wire logic              link_clock,
    input  wire logic              link_nrst,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   scl_out,
    output logic                   scl_oe,
    output logic                   wake_request
);
    if (ADDR_W < 4) begin : g_addr_check
        $error("two_wire_unit: ADDR_W must be at least 4");
    end

    sys_state_t  s;
    sys_state_t  next_s;
    logic        dual;
    logic        debug_run;
    logic        frozen;
    logic        quiet;
    logic        host_run;
    logic        mapped;
    logic        byte_edge;
    logic        addr_edge;
    logic        hd_wr;
    logic        hd_rd;
    logic        cd_acc;
    logic [1:0]  client_hold_sel;
    logic        byte_tog;
    logic        addr_tog;

    function automatic logic [7:0] hold_cycles(input logic [1:0] sel);
        unique case (sel)
            `HOLD_OFF:   hold_cycles = '0;
            `HOLD_SHORT: hold_cycles = 8'(`CEIL_CYC(`HOLD_SHORT_NS));
            `HOLD_MID:   hold_cycles = 8'(`CEIL_CYC(`HOLD_MID_NS));
            default:     hold_cycles = 8'(`CEIL_CYC(`HOLD_LONG_NS));
        endcase
    endfunction : hold_cycles

    function automatic logic [7:0] write_mask(input logic [ADDR_W-1:0] idx);
        unique case (idx)
            ADDR_W'(`OFS_SHARED):  write_mask = `MASK_SHARED;
            ADDR_W'(`OFS_DUAL):    write_mask = `MASK_DUAL;
            ADDR_W'(`OFS_DEBUG):   write_mask = `MASK_DEBUG;
            ADDR_W'(`OFS_HCTRL1):  write_mask = `MASK_HCTRL1;
            ADDR_W'(`OFS_HCTRL2):  write_mask = `MASK_HCTRL2;
            ADDR_W'(`OFS_CCTRL1):  write_mask = `MASK_CCTRL1;
            ADDR_W'(`OFS_CCTRL2):  write_mask = `MASK_CCTRL2;
            ADDR_W'(`OFS_HSTATUS): write_mask = `REG_RESET;
            ADDR_W'(`OFS_CSTATUS): write_mask = `REG_RESET;
            default:               write_mask = `MASK_FULL;
        endcase
    endfunction : write_mask

    always_comb begin
        next_s = s;
        dual = s.regs[`OFS_DUAL][`POS_DUAL_EN];
        debug_run = s.regs[`OFS_DEBUG][`POS_DBG_RUN];
        frozen = cpu_halt && !debug_run;
        quiet = cpu_halt && debug_run;
        host_run = s.regs[`OFS_HCTRL1][`POS_HOST_EN] && !sleep && !frozen;
        mapped = addr < ADDR_W'(`REG_COUNT);
        hd_wr = wr_en && addr == ADDR_W'(`OFS_HDATA);
        hd_rd = rd_en && addr == ADDR_W'(`OFS_HDATA);
        cd_acc = (wr_en || rd_en) && addr == ADDR_W'(`OFS_CDATA);
        byte_edge = s.byte_sync[1] ^ s.byte_sync[2];
        addr_edge = s.addr_sync[1] ^ s.addr_sync[2];
        next_s.byte_sync = {s.byte_sync[1:0], byte_tog};
        next_s.addr_sync = {s.addr_sync[1:0], addr_tog};
        next_s.host_go = 1'b0;
        next_s.rdata = '0;

        if (wr_en && mapped) begin
            if (addr == ADDR_W'(`OFS_HSTATUS) || addr == ADDR_W'(`OFS_CSTATUS)) begin
                next_s.regs[addr] = s.regs[addr] & ~wdata;
            end else begin
                next_s.regs[addr] = wdata & write_mask(addr);
            end
        end
        if (rd_en && mapped) begin
            next_s.rdata = s.regs[addr];
        end

        // a data access while debug-halted with keep-running set must not disturb the transfer
        if (!quiet) begin
            if (hd_rd) begin
                next_s.regs[`OFS_HSTATUS][`POS_FLAG_HI] = 1'b0;
            end
            if (hd_wr) begin
                next_s.regs[`OFS_HSTATUS][`POS_FLAG_LO] = 1'b0;
            end
            if (cd_acc) begin
                next_s.regs[`OFS_CSTATUS][`POS_FLAG_HI] = 1'b0;
            end
            next_s.host_go = hd_wr && host_run;
        end

        // sets come after clears so an event in a clearing cycle survives
        if (!frozen) begin
            if (byte_edge) begin
                next_s.regs[`OFS_CSTATUS][`POS_FLAG_HI] = 1'b1;
            end
            if (addr_edge) begin
                next_s.regs[`OFS_CSTATUS][`POS_FLAG_LO] = 1'b1;
            end
            if (host_read_done && host_run) begin
                next_s.regs[`OFS_HSTATUS][`POS_FLAG_HI] = 1'b1;
            end
            if (host_write_done && host_run) begin
                next_s.regs[`OFS_HSTATUS][`POS_FLAG_LO] = 1'b1;
            end
        end

        next_s.client_irq =
            (next_s.regs[`OFS_CSTATUS][`POS_FLAG_HI] && next_s.regs[`OFS_CCTRL1][`POS_FLAG_HI])
            || (next_s.regs[`OFS_CSTATUS][`POS_FLAG_LO] && next_s.regs[`OFS_CCTRL1][`POS_FLAG_LO]);
        next_s.host_irq =
            (next_s.regs[`OFS_HSTATUS][`POS_FLAG_HI] && next_s.regs[`OFS_HCTRL1][`POS_FLAG_HI])
            || (next_s.regs[`OFS_HSTATUS][`POS_FLAG_LO] && next_s.regs[`OFS_HCTRL1][`POS_FLAG_LO]);
        next_s.host_active = host_run;

        next_s.pad_host = s.regs[`OFS_SHARED][`POS_PAD_LVL];
        next_s.pad_client = dual ? s.regs[`OFS_DUAL][`POS_PAD_LVL]
                                 : s.regs[`OFS_SHARED][`POS_PAD_LVL];
        next_s.fmp_host = s.regs[`OFS_SHARED][`POS_FMP];
        next_s.fmp_client = dual ? s.regs[`OFS_DUAL][`POS_FMP]
                                 : s.regs[`OFS_SHARED][`POS_FMP];
        client_hold_sel = dual ? s.regs[`OFS_DUAL][`POS_HOLD_HI:`POS_HOLD_LO]
                               : s.regs[`OFS_SHARED][`POS_HOLD_HI:`POS_HOLD_LO];
        next_s.host_hold = hold_cycles(s.regs[`OFS_SHARED][`POS_HOLD_HI:`POS_HOLD_LO]);
        next_s.client_hold = hold_cycles(client_hold_sel);
        next_s.setup_cycles = s.regs[`OFS_SHARED][`POS_SETUP] ? 4'(`SETUP_EIGHT)
                                                             : 4'(`SETUP_FOUR);

        // stretch release waits the setup time after the clock returns
        if (sleep) begin
            next_s.wake_count = '0;
            next_s.clock_free = 1'b0;
        end else if (!s.clock_free) begin
            next_s.wake_count = s.wake_count + 4'h1;
            if (s.wake_count + 4'h1 >= s.setup_cycles) begin
                next_s.clock_free = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            s <= '0;
        end else if (clock_en) begin
            s <= next_s;
        end
    end

    two_wire_link u_link (
        .link_clock   (link_clock),
        .link_nrst    (link_nrst),
        .clock_en     (clock_en),
        .scl_in       (scl_in),
        .sda_in       (sda_in),
        .sleep        (sleep),
        .clock_free   (s.clock_free),
        .dual_en      (s.regs[`OFS_DUAL][`POS_DUAL_EN]),
        .client_addr  (s.regs[`OFS_CADDR][7:1]),
        .scl_out      (scl_out),
        .scl_oe       (scl_oe),
        .wake_request (wake_request),
        .byte_toggle  (byte_tog),
        .addr_toggle  (addr_tog)
    );

    assign rdata = s.rdata;
    assign host_irq = s.host_irq;
    assign client_irq = s.client_irq;
    assign host_go = s.host_go;
    assign host_active = s.host_active;
    assign pad_host = s.pad_host;
    assign pad_client = s.pad_client;
    assign fmp_host = s.fmp_host;
    assign fmp_client = s.fmp_client;
    assign host_hold_cycles = s.host_hold;
    assign client_hold_cycles = s.client_hold;
    assign setup_cycles = s.setup_cycles;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    client_req_a: assert property (
        client_irq == ((s.regs[`OFS_CSTATUS][7] && s.regs[`OFS_CCTRL1][7])
                    || (s.regs[`OFS_CSTATUS][6] && s.regs[`OFS_CCTRL1][6])))
        else $error("client request does not follow its flags");
    host_req_a: assert property (
        host_irq == ((s.regs[`OFS_HSTATUS][7] && s.regs[`OFS_HCTRL1][7])
                  || (s.regs[`OFS_HSTATUS][6] && s.regs[`OFS_HCTRL1][6])))
        else $error("host request does not follow its flags");
    byte_flag_set_a: assert property (
        clock_en && !frozen && byte_edge |=> s.regs[`OFS_CSTATUS][7])
        else $error("client byte event lost");
    frozen_ignore_a: assert property (
        clock_en && frozen && addr_edge && !s.regs[`OFS_CSTATUS][6]
        |=> !s.regs[`OFS_CSTATUS][6])
        else $error("frozen controller took an event");
    sleep_host_a: assert property (
        clock_en && sleep |=> !host_go && !host_active)
        else $error("host active during sleep");
    quiet_data_a: assert property (
        clock_en && quiet && hd_wr |=> !host_go)
        else $error("halted data write started a transfer");
    release_wait_a: assert property (
        $rose(s.clock_free) |-> !$past(sleep, 1) && !$past(sleep, 4))
        else $error("clock released before setup time");
    hold_map_a: assert property (
        clock_en |=> client_hold_cycles == hold_cycles($past(client_hold_sel)))
        else $error("client hold count wrong");
    fast_plus_a: assert property (
        clock_en |=> fmp_host == $past(s.regs[`OFS_SHARED][`POS_FMP]))
        else $error("fast-plus select wrong");
    single_pad_a: assert property (
        clock_en && !dual |=> pad_client == pad_host)
        else $error("client threshold used outside dual mode");

    byte_event_c: cover property (clock_en && byte_edge && !frozen);
    wake_release_c: cover property ($rose(s.clock_free));
    quiet_write_c: cover property (clock_en && quiet && hd_wr);
endmodule : two_wire_unit
`default_nettype wire

// file: verification/bus_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module bus_host_model (
    input  wire logic link_clock,
    input  wire logic scl_line,
    output logic      scl_drive,
    output logic      sda_drive
);
    // open drain: 1 releases the line to its pull-up
    initial begin
        scl_drive = 1'b1;
        sda_drive = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge link_clock);
    endtask : tick
    // a client may stretch the clock; bounded wait so a stuck line cannot hang the run
    task automatic release_scl();
        int k;
        k = 0;
        scl_drive <= 1'b1;
        tick(1);
        while (scl_line !== 1'b1 && k < 4000) begin
            tick(1);
            k++;
        end
        tick(3);
    endtask : release_scl
    // start, address and direction, n data bytes, each with a released
    // acknowledge slot, then stop
    task automatic send_addr(input logic [6:0] a, input logic rw, input logic [7:0] d,
                             input int n);
        logic [8:0] b;
        tick(2);
        sda_drive <= 1'b0;
        tick(4);
        for (int f = 0; f <= n; f++) begin
            b = (f == 0) ? {a, rw, 1'b1} : {d, 1'b1};
            for (int i = 8; i >= 0; i--) begin
                scl_drive <= 1'b0;
                tick(1);
                sda_drive <= b[i];
                tick(3);
                release_scl();
            end
        end
        scl_drive <= 1'b0;
        tick(1);
        sda_drive <= 1'b0;
        tick(3);
        release_scl();
        sda_drive <= 1'b1;
        tick(4);
    endtask : send_addr
endmodule : bus_host_model
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "two_wire_params.svh"
module testbench;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        link_clock = 1'b0;
    logic        link_nrst = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        sleep = 1'b0;
    logic        cpu_halt = 1'b0;
    logic        rd_done = 1'b0;
    logic        wr_done = 1'b0;
    wire  [7:0]  rdata, host_hold_cycles, client_hold_cycles;
    wire  [3:0]  setup_cycles;
    wire         host_irq, client_irq, host_go, host_active, pad_host, pad_client;
    wire         fmp_host, fmp_client, scl_oe, wake_request, scl_drive, sda_drive, scl_out;
    // open drain: the line goes low where the host model or the unit drives a low
    wire         scl_line = scl_drive & (scl_out | ~scl_oe);
    logic [7:0]  model [15] = '{default: 8'h00};
    logic [7:0]  wmask [15] = '{`MASK_SHARED, `MASK_DUAL, `MASK_DEBUG, `MASK_HCTRL1,
        `MASK_HCTRL2, 8'h00, 8'hFF, 8'hFF, 8'hFF, `MASK_CCTRL1, `MASK_CCTRL2, 8'h00,
        8'hFF, 8'hFF, 8'hFF};
    logic [31:0] seed = 32'hCB3B5975;
    int          n_fail = 0;
    int          n_checks = 0;
    int          n_go = 0;
    always #2 clock = ~clock;
    always #15 link_clock = ~link_clock;
    always @(posedge clock) if (host_go === 1'b1) n_go++;
    two_wire_unit two_wire_unit_inst (.clock(clock), .nrst(nrst), .clock_en(1'b1),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .sleep(sleep), .cpu_halt(cpu_halt), .host_read_done(rd_done),
        .host_write_done(wr_done), .host_irq(host_irq), .client_irq(client_irq),
        .host_go(host_go), .host_active(host_active), .pad_host(pad_host),
        .pad_client(pad_client), .fmp_host(fmp_host), .fmp_client(fmp_client),
        .host_hold_cycles(host_hold_cycles), .client_hold_cycles(client_hold_cycles),
        .setup_cycles(setup_cycles), .link_clock(link_clock), .link_nrst(link_nrst),
        .scl_in(scl_line), .sda_in(sda_drive), .scl_out(scl_out), .scl_oe(scl_oe),
        .wake_request(wake_request));
    bus_host_model bus_host_model_inst (.link_clock(link_clock), .scl_line(scl_line),
        .scl_drive(scl_drive), .sda_drive(sda_drive));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    function automatic logic [7:0] hold(input logic [1:0] s);
        int ns [4] = '{0, 50, 300, 500};
        return 8'((ns[s] + 3) / 4);
    endfunction : hold
    task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, s);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : idle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        if (a < 4'hF) model[a] = (model[a] & ~wmask[a]) | (d & wmask[a]);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic rchk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        logic [7:0] d;
        rd(a, d);
        check("register", d & m, e & m);
    endtask : rchk
    task automatic pulse(input bit w);
        @(posedge clock);
        if (w) wr_done <= 1'b1;
        else rd_done <= 1'b1;
        @(posedge clock);
        wr_done <= 1'b0;
        rd_done <= 1'b0;
        idle(2);
    endtask : pulse
    task automatic set_sleep(input logic s);
        @(posedge clock);
        sleep <= s;
        idle(3);
    endtask : set_sleep
    initial begin
        repeat (60000) @(posedge clock);
        n_fail++;
        conclude();
    end
    initial begin
        logic [7:0] v, d, hst;
        int g;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge link_clock);
        link_nrst <= 1'b1;
        idle(2);
        check("host_irq", host_irq, 1'b0);
        for (int i = 0; i < 16; i++) rchk(i[3:0], 8'h00, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            v[3:2] = i[1:0];
            d = rnd();
            d[3:2] = ~i[1:0];
            d[0] = i[2];
            wr(4'h0, v);
            wr(4'h1, d);
            rchk(4'h0, model[0], 8'hFF);
            rchk(4'h1, model[1], 8'hFF);
            check("pad_host", pad_host, v[6]);
            check("setup", setup_cycles, v[4] ? 4'h8 : 4'h4);
            check("hold", host_hold_cycles, hold(v[3:2]));
            check("fmp_host", fmp_host, v[1]);
            check("pad_client", pad_client, d[0] ? d[6] : v[6]);
            check("hold_client", client_hold_cycles, hold(d[0] ? d[3:2] : v[3:2]));
            check("fmp_client", fmp_client, d[0] ? d[1] : v[1]);
        end
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h00);
        // data and status registers have side effects, so they are left out here
        for (int i = 2; i < 16; i++) if (!(i inside {5, 8, 11, 13})) begin
            v = rnd();
            wr(i[3:0], v);
            rchk(i[3:0], i < 15 ? model[i] : 8'h00, 8'hFF);
            wr(i[3:0], 8'h00);
        end
        wr(4'h3, 8'hC1);
        idle(2);
        check("host_active", host_active, 1'b1);
        pulse(1);
        hst = 8'h40;
        rchk(4'h5, hst, 8'hC0);
        check("host_irq", host_irq, 1'b1);
        pulse(0);
        hst = 8'hC0;
        rchk(4'h5, hst, 8'hC0);
        wr(4'h5, 8'h40);
        hst = 8'h80;
        rchk(4'h5, hst, 8'hC0);
        check("host_irq", host_irq, 1'b1);
        rd(4'h8, v);
        hst = 8'h00;
        rchk(4'h5, hst, 8'hC0);
        check("host_irq", host_irq, 1'b0);
        wr(4'h3, 8'h81);
        pulse(1);
        check("host_irq", host_irq, 1'b0);
        wr(4'h3, 8'hC1);
        idle(2);
        check("host_irq", host_irq, 1'b1);
        g = n_go;
        wr(4'h8, 8'h5A);
        idle(3);
        check("host_go", n_go - g, 1);
        rchk(4'h5, 8'h00, 8'hC0);
        set_sleep(1'b1);
        check("host_active", host_active, 1'b0);
        pulse(1);
        wr(4'h8, 8'h3C);
        idle(3);
        rchk(4'h5, 8'h00, 8'hC0);
        check("host_go", n_go - g, 1);
        set_sleep(1'b0);
        @(posedge clock);
        cpu_halt <= 1'b1;
        idle(3);
        check("host_active", host_active, 1'b0);
        pulse(1);
        wr(4'h8, 8'h3C);
        idle(3);
        rchk(4'h5, 8'h00, 8'hC0);
        check("host_go", n_go - g, 1);
        wr(4'h2, 8'h01);
        idle(3);
        check("host_active", host_active, 1'b1);
        pulse(1);
        pulse(0);
        rchk(4'h5, 8'hC0, 8'hC0);
        wr(4'h8, 8'h3C);
        rd(4'h8, v);
        idle(3);
        rchk(4'h5, 8'hC0, 8'hC0);
        check("host_go", n_go - g, 1);
        @(posedge clock);
        cpu_halt <= 1'b0;
        wr(4'h5, 8'hC0);
        wr(4'h2, 8'h00);
        wr(4'hC, 8'h52);
        wr(4'h9, 8'hC1);
        set_sleep(1'b1);
        bus_host_model_inst.send_addr(7'h2A, 1'b0, 8'h00, 0);
        idle(60);
        check("wake", wake_request, 1'b0);
        fork
            bus_host_model_inst.send_addr(7'h29, 1'b0, rnd(), 1);
        join_none
        for (int k = 0; k < 3000 && wake_request !== 1'b1; k++) @(posedge clock);
        idle(20);
        check("wake", wake_request, 1'b1);
        check("stretch", scl_oe, 1'b1);
        set_sleep(1'b0);
        wait fork;
        idle(60);
        check("stretch", scl_oe, 1'b0);
        check("wake", wake_request, 1'b0);
        rchk(4'hB, 8'hC0, 8'hC0);
        check("client_irq", client_irq, 1'b1);
        wr(4'hB, 8'h40);
        idle(3);
        check("client_irq", client_irq, 1'b1);
        wr(4'hB, 8'h80);
        idle(3);
        check("client_irq", client_irq, 1'b0);
        wr(4'h1, 8'h01);
        set_sleep(1'b1);
        bus_host_model_inst.send_addr(7'h2A, 1'b0, 8'h00, 0);
        idle(10);
        check("wake", wake_request, 1'b1);
        set_sleep(1'b0);
        conclude();
    end
endmodule : testbench
`default_nettype wire
